// *** osm_pkg.sv ***
// shared constants, types and register map for the indirect-capable execution datapath
package osm_pkg;

    localparam int AXI_AW = 8;
    localparam int PTR_W = 16;
    localparam int DMEM_AW = 10;
    localparam int BANK_W = 3;
    localparam int FILE_W = 7;
    localparam int K_W = 6;

    // register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PTR0 = 8'h0C;
    localparam logic [7:0] OFF_PTR1 = 8'h10;
    localparam logic [7:0] OFF_BANK = 8'h14;
    localparam logic [7:0] OFF_MADDR = 8'h18;
    localparam logic [7:0] OFF_MDATA = 8'h1C;

    // status field positions
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_CARRY_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [BANK_W-1:0] BANK_RST = 3'h0;
    localparam logic [DMEM_AW-1:0] MADDR_RST = 10'h000;

    // file addresses that act as indirect windows
    localparam logic [FILE_W-1:0] FILE_WIN0 = 7'h00;
    localparam logic [FILE_W-1:0] FILE_WIN1 = 7'h01;

    // pointer update select encodings
    localparam logic [1:0] MM_PRE_INC = 2'h0;
    localparam logic [1:0] MM_PRE_DEC = 2'h1;
    localparam logic [1:0] MM_POST_INC = 2'h2;
    localparam logic [1:0] MM_POST_DEC = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_OR = 3'h0,
        OP_LSL = 3'h1,
        OP_LSR = 3'h2,
        OP_MOV = 3'h3,
        OP_IND = 3'h4
    } osm_op_t;

    typedef struct packed {
        logic [K_W-1:0] offset_k;
        logic offset_mode;
        logic [1:0] update_sel;
        logic ptr_sel;
        logic [FILE_W-1:0] file_addr;
        logic dest_sel;
        osm_op_t op;
    } osm_cmd_t;

    localparam int CMD_W = $bits(osm_cmd_t);
    localparam osm_cmd_t CMD_RST = '0;

endpackage

// *** osm_alu.sv ***
// combinational result and flag logic for or, shifts, move and indirect load
module osm_alu import osm_pkg::*; (
    input osm_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] file_val,
    output logic [7:0] result,
    output logic carry,
    output logic carry_upd,
    output logic zero
);

    always_comb begin
        result = file_val;
        carry = 1'b0;
        carry_upd = 1'b0;
        case (op)
            OP_OR: begin
                result = acc | file_val;
            end
            OP_LSL: begin
                result = {file_val[6:0], 1'b0};
                carry = file_val[7];
                carry_upd = 1'b1;
            end
            OP_LSR: begin
                result = {1'b0, file_val[7:1]};
                carry = file_val[0];
                carry_upd = 1'b1;
            end
            OP_MOV: begin
                result = file_val;
            end
            OP_IND: begin
                result = file_val;
            end
            default: begin
                result = file_val;
            end
        endcase
        zero = (result == 8'h00);
    end

endmodule

// *** osm_dmem.sv ***
// byte-wide data memory with registered read port
module osm_dmem import osm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic we,
    input wire logic [DMEM_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [DMEM_AW-1:0] raddr,
    output logic [7:0] rdata_q
);

    logic [7:0] mem [0:(1<<DMEM_AW)-1];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

// *** osm_exec.sv ***
// execution datapath with axi4-lite register access
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
module osm_exec import osm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic zero_flag,
    output logic carry_flag,
    output logic busy
);

    typedef enum logic [2:0] {S_IDLE, S_RD1, S_RD2, S_OP_RD, S_OP_EX} osm_state_t;

    osm_state_t state_q, state_d;
    osm_cmd_t cmd_q, cmd_d;
    logic [7:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic carry_q, carry_d;
    logic [PTR_W-1:0] ptr_q [0:1];
    logic [PTR_W-1:0] ptr_d [0:1];
    logic [BANK_W-1:0] bank_q, bank_d;
    logic [DMEM_AW-1:0] maddr_q, maddr_d;
    logic [AXI_AW-1:0] raddr_q, raddr_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    logic aw_go, ar_go;
    logic [31:0] wmerged;
    logic [PTR_W-1:0] cur_ptr;
    logic [PTR_W-1:0] ind_ea;
    logic [DMEM_AW-1:0] op_addr;
    logic mem_we;
    logic [DMEM_AW-1:0] mem_waddr, mem_raddr;
    logic [7:0] mem_wdata, mem_rdata;
    logic [7:0] alu_res;
    logic alu_c, alu_cu, alu_z;

    function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
        reg_hit = (a == OFF_CMD) || (a == OFF_ACC) || (a == OFF_STATUS) || (a == OFF_PTR0) ||
                  (a == OFF_PTR1) || (a == OFF_BANK) || (a == OFF_MADDR) || (a == OFF_MDATA);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [PTR_W-1:0] eff_addr(input osm_cmd_t c, input logic [PTR_W-1:0] p);
        logic [PTR_W-1:0] r;
        r = p;
        if (c.offset_mode) begin
            r = p + {{(PTR_W-K_W){c.offset_k[K_W-1]}}, c.offset_k};
        end else if (c.update_sel == MM_PRE_INC) begin
            r = p + 16'h0001;
        end else if (c.update_sel == MM_PRE_DEC) begin
            r = p - 16'h0001;
        end
        eff_addr = r;
    endfunction

    function automatic logic [PTR_W-1:0] next_ptr(input osm_cmd_t c, input logic [PTR_W-1:0] p);
        logic [PTR_W-1:0] r;
        r = p;
        if (!c.offset_mode) begin
            if (c.update_sel == MM_PRE_INC || c.update_sel == MM_POST_INC) begin
                r = p + 16'h0001;
            end else begin
                r = p - 16'h0001;
            end
        end
        next_ptr = r;
    endfunction

    assign aw_go = (state_q == S_IDLE) && !bvalid_q && s_axi_awvalid && s_axi_wvalid;
    assign ar_go = (state_q == S_IDLE) && !rvalid_q && s_axi_arvalid && !aw_go;
    assign s_axi_awready = aw_go;
    assign s_axi_wready = aw_go;
    assign s_axi_arready = ar_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign zero_flag = zero_q;
    assign carry_flag = carry_q;
    assign busy = (state_q == S_OP_RD) || (state_q == S_OP_EX);
    assign cur_ptr = ptr_q[cmd_q.ptr_sel];
    assign ind_ea = eff_addr(cmd_q, cur_ptr);

    // physical data address of the operand
    always_comb begin
        if (cmd_q.op == OP_IND) begin
            op_addr = ind_ea[DMEM_AW-1:0];
        end else if (cmd_q.file_addr == FILE_WIN0) begin
            op_addr = ptr_q[0][DMEM_AW-1:0];
        end else if (cmd_q.file_addr == FILE_WIN1) begin
            op_addr = ptr_q[1][DMEM_AW-1:0];
        end else begin
            op_addr = {bank_q, cmd_q.file_addr};
        end
    end

    always_comb begin
        wmerged = 32'h0000_0000;
        case (s_axi_awaddr)
            OFF_CMD: wmerged = merge({{(32-CMD_W){1'b0}}, cmd_q}, s_axi_wdata, s_axi_wstrb);
            OFF_ACC: wmerged = merge({24'h00_0000, acc_q}, s_axi_wdata, s_axi_wstrb);
            OFF_STATUS: wmerged = merge({30'h0000_0000, carry_q, zero_q}, s_axi_wdata, s_axi_wstrb);
            OFF_PTR0: wmerged = merge({16'h0000, ptr_q[0]}, s_axi_wdata, s_axi_wstrb);
            OFF_PTR1: wmerged = merge({16'h0000, ptr_q[1]}, s_axi_wdata, s_axi_wstrb);
            OFF_BANK: wmerged = merge({29'h0000_0000, bank_q}, s_axi_wdata, s_axi_wstrb);
            OFF_MADDR: wmerged = merge({22'h00_0000, maddr_q}, s_axi_wdata, s_axi_wstrb);
            default: wmerged = s_axi_wdata;
        endcase
    end

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        acc_d = acc_q;
        zero_d = zero_q;
        carry_d = carry_q;
        ptr_d[0] = ptr_q[0];
        ptr_d[1] = ptr_q[1];
        bank_d = bank_q;
        maddr_d = maddr_q;
        raddr_d = raddr_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        mem_we = 1'b0;
        mem_waddr = maddr_q;
        mem_wdata = s_axi_wdata[7:0];
        mem_raddr = maddr_q;
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        case (state_q)
            S_IDLE: begin
                if (aw_go) begin
                    bvalid_d = 1'b1;
                    bresp_d = reg_hit(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
                    case (s_axi_awaddr)
                        OFF_CMD: begin
                            cmd_d = osm_cmd_t'(wmerged[CMD_W-1:0]);
                            state_d = S_OP_RD;
                        end
                        OFF_ACC: acc_d = wmerged[7:0];
                        OFF_STATUS: begin
                            zero_d = wmerged[STAT_ZERO_BIT];
                            carry_d = wmerged[STAT_CARRY_BIT];
                        end
                        OFF_PTR0: ptr_d[0] = wmerged[PTR_W-1:0];
                        OFF_PTR1: ptr_d[1] = wmerged[PTR_W-1:0];
                        OFF_BANK: bank_d = wmerged[BANK_W-1:0];
                        OFF_MADDR: maddr_d = wmerged[DMEM_AW-1:0];
                        OFF_MDATA: mem_we = s_axi_wstrb[0];
                        default: state_d = S_IDLE;
                    endcase
                end else if (ar_go) begin
                    raddr_d = s_axi_araddr;
                    state_d = S_RD1;
                end
            end
            S_RD1: state_d = S_RD2;
            S_RD2: begin
                rvalid_d = 1'b1;
                rresp_d = reg_hit(raddr_q) ? RESP_OKAY : RESP_SLVERR;
                case (raddr_q)
                    OFF_CMD: rdata_d = {{(32-CMD_W){1'b0}}, cmd_q};
                    OFF_ACC: rdata_d = {24'h00_0000, acc_q};
                    OFF_STATUS: rdata_d = {29'h0000_0000, 1'b0, carry_q, zero_q};
                    OFF_PTR0: rdata_d = {16'h0000, ptr_q[0]};
                    OFF_PTR1: rdata_d = {16'h0000, ptr_q[1]};
                    OFF_BANK: rdata_d = {29'h0000_0000, bank_q};
                    OFF_MADDR: rdata_d = {22'h00_0000, maddr_q};
                    OFF_MDATA: rdata_d = {24'h00_0000, mem_rdata};
                    default: rdata_d = 32'h0000_0000;
                endcase
                state_d = S_IDLE;
            end
            S_OP_RD: begin
                mem_raddr = op_addr;
                state_d = S_OP_EX;
            end
            S_OP_EX: begin
                mem_raddr = op_addr;
                if (cmd_q.op != OP_IND && cmd_q.dest_sel) begin
                    mem_we = 1'b1;
                    mem_waddr = op_addr;
                    mem_wdata = alu_res;
                end else begin
                    acc_d = alu_res;
                end
                zero_d = alu_z;
                if (alu_cu) begin
                    carry_d = alu_c;
                end
                if (cmd_q.op == OP_IND) begin
                    ptr_d[cmd_q.ptr_sel] = next_ptr(cmd_q, cur_ptr);
                end
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_IDLE;
            cmd_q <= CMD_RST;
            acc_q <= ACC_RST;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
            ptr_q[0] <= PTR_RST;
            ptr_q[1] <= PTR_RST;
            bank_q <= BANK_RST;
            maddr_q <= MADDR_RST;
            raddr_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            acc_q <= acc_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            ptr_q[0] <= ptr_d[0];
            ptr_q[1] <= ptr_d[1];
            bank_q <= bank_d;
            maddr_q <= maddr_d;
            raddr_q <= raddr_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    osm_alu u_alu (
        .op(cmd_q.op),
        .acc(acc_q),
        .file_val(mem_rdata),
        .result(alu_res),
        .carry(alu_c),
        .carry_upd(alu_cu),
        .zero(alu_z)
    );

    osm_dmem u_dmem (
        .aclk(aclk),
        .aresetn(aresetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_q(mem_rdata)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ex_now;
    assign ex_now = (state_q == S_OP_EX);

    sequence s_pre_inc_issue;
        state_q == S_OP_RD && cmd_q.op == OP_IND && !cmd_q.offset_mode && cmd_q.update_sel == MM_PRE_INC;
    endsequence
    sequence s_post_inc_issue;
        state_q == S_OP_RD && cmd_q.op == OP_IND && !cmd_q.offset_mode && cmd_q.update_sel == MM_POST_INC;
    endsequence

    property p_or_to_acc;
        ex_now && cmd_q.op == OP_OR && !cmd_q.dest_sel |=> acc_q == ($past(acc_q) | $past(mem_rdata)) &&
            carry_q == $past(carry_q);
    endproperty
    a_or_to_acc: assert property (p_or_to_acc) else $error("or result or carry wrong");
    property p_lsl;
        ex_now && cmd_q.op == OP_LSL |=> carry_q == $past(mem_rdata[7]);
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift carry wrong");
    property p_lsr;
        ex_now && cmd_q.op == OP_LSR && !cmd_q.dest_sel |=> acc_q == {1'b0, $past(mem_rdata[7:1])} &&
            carry_q == $past(mem_rdata[0]);
    endproperty
    a_lsr: assert property (p_lsr) else $error("right shift result wrong");
    property p_dest_file;
        ex_now && cmd_q.op != OP_IND && cmd_q.dest_sel |-> mem_we && mem_waddr == op_addr ##1 $stable(acc_q);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination not honoured");
    property p_mov_same;
        ex_now && cmd_q.op == OP_MOV && cmd_q.dest_sel |-> mem_wdata == mem_rdata ##1
            zero_q == ($past(mem_rdata) == 8'h00);
    endproperty
    a_mov_same: assert property (p_mov_same) else $error("move to self altered data or zero");
    property p_ind_load;
        ex_now && cmd_q.op == OP_IND |=> acc_q == $past(mem_rdata) && carry_q == $past(carry_q) &&
            zero_q == ($past(mem_rdata) == 8'h00);
    endproperty
    a_ind_load: assert property (p_ind_load) else $error("indirect load wrong");
    property p_pre_inc;
        s_pre_inc_issue |-> mem_raddr == DMEM_AW'(cur_ptr + 16'h0001) ##2 cur_ptr == $past(cur_ptr, 2) + 16'h0001;
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre increment wrong");
    property p_post_inc;
        s_post_inc_issue |-> mem_raddr == cur_ptr[DMEM_AW-1:0] ##2 cur_ptr == $past(cur_ptr, 2) + 16'h0001;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post increment wrong");
    property p_offset;
        state_q == S_OP_RD && cmd_q.op == OP_IND && cmd_q.offset_mode |-> ##2 $stable(ptr_q[0]) && $stable(ptr_q[1]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset mode moved pointer");

endmodule

// *** tb_or_shift_move_indirect_exec.sv ***
// self-checking bench for the execution datapath driven over axi4-lite
module tb_or_shift_move_indirect_exec import osm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_AW-1:0] awaddr = '0;
    logic [AXI_AW-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, zero_flag, carry_flag, busy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;

    osm_exec dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .zero_flag(zero_flag), .carry_flag(carry_flag), .busy(busy)
    );

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel released at the edge that takes it
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(what, exp, d);
    endtask

    task automatic mwr(input logic [9:0] a, input logic [7:0] v);
        wr(OFF_MADDR, {22'h0, a});
        wr(OFF_MDATA, {24'h0, v});
    endtask

    task automatic mchk(input logic [9:0] a, input logic [7:0] v);
        wr(OFF_MADDR, {22'h0, a});
        rdc("memory", OFF_MDATA, {24'h0, v});
    endtask

    task automatic flg(input logic z, input logic c);
        chk("zero_flag", {31'h0, z}, {31'h0, zero_flag});
        chk("carry_flag", {31'h0, c}, {31'h0, carry_flag});
    endtask

    task automatic cmd(input osm_op_t op, input logic dst, input logic [FILE_W-1:0] fa, input logic ps,
                       input logic [1:0] us, input logic om, input logic [K_W-1:0] k);
        osm_cmd_t c;
        c = CMD_RST;
        c.op = op;
        c.dest_sel = dst;
        c.file_addr = fa;
        c.ptr_sel = ps;
        c.update_sel = us;
        c.offset_mode = om;
        c.offset_k = k;
        wr(OFF_CMD, 32'(c));
        chk("busy", 32'h0000_0001, {31'h0, busy});
        while (busy !== 1'b0) @(posedge aclk);
    endtask

    localparam logic [7:0] SH_IN [6] = '{8'h81, 8'h80, 8'h01, 8'hFE, 8'h3C, 8'h00};

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        osm_op_t op;
        logic [7:0] fin, ex;
        logic ec, ez;
        logic [15:0] np, ea;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("acc reset", OFF_ACC, 32'h0000_0000);
        rdc("status reset", OFF_STATUS, 32'h0000_0000);
        rdc("ptr1 reset", OFF_PTR1, 32'h0000_0000);
        axr(8'h20, d, r);
        chk("unmapped rdata", 32'h0000_0000, d);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axw(8'h24, 32'h0000_00FF, r);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        // or into accumulator, then into file, in bank 2
        wr(OFF_BANK, 32'h0000_0002);
        mwr(10'h125, 8'hA0);
        wr(OFF_ACC, 32'h0000_000F);
        wr(OFF_STATUS, 32'h0000_0003);
        cmd(OP_OR, 1'b0, 7'h25, 1'b0, 2'h0, 1'b0, 6'h00);
        rdc("or acc", OFF_ACC, 32'h0000_00AF);
        flg(1'b0, 1'b1);
        mchk(10'h125, 8'hA0);
        wr(OFF_ACC, 32'h0000_0050);
        cmd(OP_OR, 1'b1, 7'h25, 1'b0, 2'h0, 1'b0, 6'h00);
        mchk(10'h125, 8'hF0);
        rdc("or acc kept", OFF_ACC, 32'h0000_0050);
        mwr(10'h125, 8'h00);
        wr(OFF_ACC, 32'h0000_0000);
        cmd(OP_OR, 1'b0, 7'h25, 1'b0, 2'h0, 1'b0, 6'h00);
        flg(1'b1, 1'b1);
        // shifts and moves, both destinations, flags preset opposite to the shift result
        for (int i = 0; i < 6; i++) begin
            op = i < 2 ? OP_LSL : (i < 4 ? OP_LSR : OP_MOV);
            fin = SH_IN[i];
            ex = op == OP_LSL ? {fin[6:0], 1'b0} : (op == OP_LSR ? {1'b0, fin[7:1]} : fin);
            ec = op == OP_LSL ? fin[7] : (op == OP_LSR ? fin[0] : i[0]);
            ez = ex == 8'h00;
            mwr(10'h125, fin);
            wr(OFF_ACC, 32'h0000_0055);
            wr(OFF_STATUS, {30'h0, op == OP_MOV ? ec : ~ec, ~ez});
            cmd(op, i[0], 7'h25, 1'b0, 2'h0, 1'b0, 6'h00);
            mchk(10'h125, i[0] ? ex : fin);
            rdc("shift or move acc", OFF_ACC, {24'h0, i[0] ? 8'h55 : ex});
            flg(ez, ec);
        end
        // window registers follow their pointers
        wr(OFF_PTR0, 32'h0000_0200);
        mwr(10'h200, 8'h5A);
        cmd(OP_MOV, 1'b0, FILE_WIN0, 1'b0, 2'h0, 1'b0, 6'h00);
        rdc("window0 acc", OFF_ACC, 32'h0000_005A);
        wr(OFF_PTR1, 32'h0000_0201);
        mwr(10'h201, 8'h03);
        cmd(OP_OR, 1'b1, FILE_WIN1, 1'b0, 2'h0, 1'b0, 6'h00);
        mchk(10'h201, 8'h5B);
        rdc("window1 ptr", OFF_PTR1, 32'h0000_0201);
        // indirect load, all four pointer update selections
        for (int a = 16'h02FF; a <= 16'h0301; a++) begin
            mwr(10'(a), 8'(a) + 8'h40);
        end
        for (int m = 0; m < 4; m++) begin
            np = m[0] ? 16'h02FF : 16'h0301;
            ea = m[1] ? 16'h0300 : np;
            wr(OFF_PTR1, 32'h0000_0300);
            wr(OFF_STATUS, 32'h0000_0003);
            cmd(OP_IND, 1'b0, 7'h00, 1'b1, 2'(m), 1'b0, 6'h00);
            rdc("indirect acc", OFF_ACC, {24'h0, ea[7:0] + 8'h40});
            rdc("indirect ptr", OFF_PTR1, {16'h0, np});
            flg(1'b0, 1'b1);
        end
        // offset mode at both ends of the literal range
        mwr(10'h0E0, 8'h00);
        mwr(10'h11F, 8'h77);
        for (int j = 0; j < 2; j++) begin
            wr(OFF_PTR0, 32'h0000_0100);
            cmd(OP_IND, 1'b0, 7'h00, 1'b0, 2'h0, 1'b1, j ? 6'h1F : 6'h20);
            rdc("offset acc", OFF_ACC, j ? 32'h0000_0077 : 32'h0000_0000);
            chk("offset zero", {31'h0, j == 0}, {31'h0, zero_flag});
            rdc("offset ptr", OFF_PTR0, 32'h0000_0100);
        end
        // pointer wraps both ways
        mwr(10'h000, 8'h99);
        wr(OFF_PTR0, 32'h0000_FFFF);
        cmd(OP_IND, 1'b0, 7'h00, 1'b0, MM_PRE_INC, 1'b0, 6'h00);
        rdc("wrap acc", OFF_ACC, 32'h0000_0099);
        rdc("wrap up ptr", OFF_PTR0, 32'h0000_0000);
        cmd(OP_IND, 1'b0, 7'h00, 1'b0, MM_POST_DEC, 1'b0, 6'h00);
        rdc("wrap down ptr", OFF_PTR0, 32'h0000_FFFF);
        rdc("wrap down acc", OFF_ACC, 32'h0000_0099);
        end_of_test();
    end
endmodule
